//--- pkg/prb_pkg.sv
/*
 * prb_pkg: constants and carrier types for the privileged return and
 * barrier unit. Assumes a 32-bit core whose pipeline presents one decoded
 * instruction word at a time on the core clock.
 */
package prb_pkg;

   // ---------------------------------------------------------------
   // instruction encodings
   // ---------------------------------------------------------------
   localparam logic [31:0] BARRIER_WORD      = 32'h0000_00c0; // shift r0,r0 by 3
   localparam logic [31:0] INT_ENABLE_MASK   = 32'hffe0_ffff; // rt field free
   localparam logic [31:0] INT_ENABLE_MATCH  = 32'h4160_6020; // misc group, rd 12, sc 1
   localparam logic [31:0] RETURN_WORD       = 32'h4200_0018;
   localparam logic [31:0] RETURN_KEEP_WORD  = 32'h4200_0058;
   localparam int          RT_LSB            = 16;

   // ---------------------------------------------------------------
   // register byte offsets on the bus
   // ---------------------------------------------------------------
   localparam logic [4:0] OFS_STATUS   = 5'h00;
   localparam logic [4:0] OFS_SHADOW   = 5'h04;
   localparam logic [4:0] OFS_RET_ADDR = 5'h08;
   localparam logic [4:0] OFS_ERR_ADDR = 5'h0c;
   localparam logic [4:0] OFS_CONFIG   = 5'h10;
   localparam logic [4:0] OFS_LINK     = 5'h14;
   localparam logic [4:0] OFS_LAST_PC  = 5'h18;

   // ---------------------------------------------------------------
   // status word fields
   // ---------------------------------------------------------------
   localparam int IE_BIT   = 0;
   localparam int EXL_BIT  = 1;
   localparam int ERL_BIT  = 2;
   localparam int BEV_BIT  = 22;
   localparam int CU0_BIT  = 28;
   localparam logic [31:0] STATUS_RST = 32'h0040_0004; // boot vector and error level

   // ---------------------------------------------------------------
   // shadow set control fields
   // ---------------------------------------------------------------
   localparam int CSS_LSB = 0;
   localparam int PSS_LSB = 6;
   localparam int HSS_LSB = 26;
   localparam int SET_W   = 4;

   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   localparam int REV_LSB       = 0;
   localparam int REV_W         = 4;
   localparam int COMPRESSED_BIT = 4;
   localparam int R6_BIT        = 5;
   localparam int KEEP_LINK_BIT = 8;
   localparam logic [REV_W-1:0] REV_RST      = 4'h2;
   localparam logic [REV_W-1:0] REV_SHADOW_MIN = 4'h2;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic [31:0] word;
      logic        in_slot;   // delay or forbidden slot of a branch
   } prb_instr_t;

   typedef struct packed {
      logic        en;
      logic [4:0]  idx;
      logic [31:0] data;
   } prb_gpr_wr_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] pc;
      logic        isa_mode;
   } prb_redirect_t;

endpackage : prb_pkg

//--- rtl/prb_core.sv
/*
 * prb_core: execution barrier, interrupt enable and both exception return
 * forms, together with the coprocessor-zero state they touch, reachable
 * over an Avalon-MM slave with waitrequest.
 * Assumes the pipeline holds an instruction on instr_in until
 * instr_ready_out is high, and that all pipeline inputs share clk_in.
 */
// Contract
// - shift of r0 into r0 by 3 decodes as the execution barrier
// - barrier stalls issue until older execution hazards clear, even in slots
// - barrier never clears instruction hazards
// - barrier forces single issue like a superscalar no-operation
// - interrupt enable decodes in misc group with rd 12 and select bit 1
// - interrupt enable writes old status to rt unless zero, then sets enable
// - status read and enable set happen atomically in one cycle
// - interrupt enable without cp0 access raises coprocessor unusable
// - exception return has no delay slot; next word is squashed
// - release 6: return in a slot raises reserved instruction
// - clearing return clears the link reservation flag
// - error level set: error address and clear it; else exception address
// - non-error return restores shadow set if rev>=2, highest>0, boot 0
// - compressed present: pc gets bits 31..1, mode gets bit 0
// - both returns clear execution and instruction hazards
// - keep-link return matches normal return but keeps link flag
// - release 6: keep-link return in a slot raises reserved instruction
// - configuration exposes a presence bit for the keep-link return
`timescale 1ns/10ps

module prb_core (
   // clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   // pipeline instruction port
   input  wire prb_pkg::prb_instr_t   instr_in,
   input  wire logic                  kernel_mode_in,
   input  wire logic                  exec_hazard_pending_in,
   input  wire logic                  link_set_in,
   output logic                       instr_ready_out,
   output logic                       single_issue_out,
   // pipeline results
   output prb_pkg::prb_gpr_wr_t       gpr_wr_out,
   output prb_pkg::prb_redirect_t     redirect_out,
   output logic                       squash_next_out,
   output logic                       clear_exec_haz_out,
   output logic                       clear_instr_haz_out,
   output logic                       exc_cp_unusable_out,
   output logic                       exc_reserved_out,
   output logic                       link_flag_out,
   output logic                       int_enable_out,
   // avalon-mm slave
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic {PRB_IDLE, PRB_BARRIER} prb_state_t;

   localparam int REV_W_L = prb_pkg::REV_W;

   prb_state_t  state_ff;
   logic [31:0] status_ff;
   logic [31:0] shadow_ff;
   logic [31:0] ret_addr_ff;
   logic [31:0] err_addr_ff;
   logic [REV_W_L-1:0] rev_ff;
   logic        compressed_ff;
   logic        r6_ff;
   logic        link_ff;
   logic [31:0] last_pc_ff;
   logic        ready_ff;
   logic        single_ff;
   prb_pkg::prb_gpr_wr_t   gpr_ff;
   prb_pkg::prb_redirect_t redir_ff;
   logic        squash_ff;
   logic        clr_exec_ff;
   logic        clr_instr_ff;
   logic        exc_cpu_ff;
   logic        exc_ri_ff;
   logic        isa_mode_ff;
   logic        wait_ff;
   logic [31:0] rdata_ff;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic        take;
   logic        is_barrier;
   logic        is_int_en;
   logic        is_ret;
   logic        is_ret_keep;
   logic        any_ret;
   logic        cp0_ok;
   logic [4:0]  rt_idx;

   assign take        = instr_in.valid && ready_ff;
   assign is_barrier  = take && (instr_in.word == prb_pkg::BARRIER_WORD);
   assign is_int_en   = take && ((instr_in.word & prb_pkg::INT_ENABLE_MASK)
                                 == prb_pkg::INT_ENABLE_MATCH);
   assign is_ret      = take && (instr_in.word == prb_pkg::RETURN_WORD);
   assign is_ret_keep = take && (instr_in.word == prb_pkg::RETURN_KEEP_WORD);
   assign any_ret     = is_ret || is_ret_keep;
   assign cp0_ok      = kernel_mode_in || status_ff[prb_pkg::CU0_BIT];
   assign rt_idx      = instr_in.word[prb_pkg::RT_LSB +: 5];

   // ---------------------------------------------------------------
   // return outcome
   // ---------------------------------------------------------------
   logic        ret_slot_fault;
   logic        ret_fault;
   logic        ret_go;
   logic        int_go;
   logic [31:0] ret_target;
   logic        shadow_restore;

   assign ret_slot_fault = r6_ff && instr_in.in_slot;
   assign ret_fault      = any_ret && (!cp0_ok || ret_slot_fault);
   assign ret_go         = any_ret && !ret_fault;
   assign int_go         = is_int_en && cp0_ok;
   assign ret_target     = status_ff[prb_pkg::ERL_BIT] ? err_addr_ff
                                                       : ret_addr_ff;
   assign shadow_restore = !status_ff[prb_pkg::ERL_BIT]
                        && (rev_ff >= prb_pkg::REV_SHADOW_MIN)
                        && (shadow_ff[prb_pkg::HSS_LSB +: prb_pkg::SET_W] != '0)
                        && !status_ff[prb_pkg::BEV_BIT];

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic        bus_wr;
   logic [31:0] bmask;
   logic [31:0] rd_mux;

   assign bus_wr = avs_write && !wait_ff;
   assign bmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   always_comb begin
      case (avs_address)
         prb_pkg::OFS_STATUS:   rd_mux = status_ff;
         prb_pkg::OFS_SHADOW:   rd_mux = shadow_ff;
         prb_pkg::OFS_RET_ADDR: rd_mux = ret_addr_ff;
         prb_pkg::OFS_ERR_ADDR: rd_mux = err_addr_ff;
         prb_pkg::OFS_CONFIG: begin
            rd_mux = '0;
            rd_mux[prb_pkg::REV_LSB +: REV_W_L]  = rev_ff;
            rd_mux[prb_pkg::COMPRESSED_BIT]      = compressed_ff;
            rd_mux[prb_pkg::R6_BIT]              = r6_ff;
            rd_mux[prb_pkg::KEEP_LINK_BIT]       = 1'b1;
         end
         prb_pkg::OFS_LINK:     rd_mux = {31'h0000_0000, link_ff};
         prb_pkg::OFS_LAST_PC:  rd_mux = last_pc_ff;
         default:               rd_mux = '0;
      endcase
   end

   // ---------------------------------------------------------------
   // avalon handshake: one wait cycle per access
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wait_ff  <= 1'b1;
         rdata_ff <= '0;
      end else begin
         wait_ff <= !((avs_read || avs_write) && wait_ff);
         if (avs_read && wait_ff) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------------
   // status word: instruction effects win over a bus write
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_ff <= prb_pkg::STATUS_RST;
      end else if (int_go) begin
         status_ff[prb_pkg::IE_BIT] <= 1'b1;
      end else if (ret_go) begin
         if (status_ff[prb_pkg::ERL_BIT]) begin
            status_ff[prb_pkg::ERL_BIT] <= 1'b0;
         end else begin
            status_ff[prb_pkg::EXL_BIT] <= 1'b0;
         end
      end else if (bus_wr && avs_address == prb_pkg::OFS_STATUS) begin
         status_ff <= merge(status_ff, avs_writedata, bmask);
      end
   end

   // ---------------------------------------------------------------
   // shadow set control
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         shadow_ff <= '0;
      end else if (ret_go && shadow_restore) begin
         shadow_ff[prb_pkg::CSS_LSB +: prb_pkg::SET_W] <=
            shadow_ff[prb_pkg::PSS_LSB +: prb_pkg::SET_W];
      end else if (bus_wr && avs_address == prb_pkg::OFS_SHADOW) begin
         shadow_ff <= merge(shadow_ff, avs_writedata, bmask);
      end
   end

   // ---------------------------------------------------------------
   // return addresses and configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ret_addr_ff   <= '0;
         err_addr_ff   <= '0;
         rev_ff        <= prb_pkg::REV_RST;
         compressed_ff <= 1'b0;
         r6_ff         <= 1'b0;
      end else if (bus_wr) begin
         case (avs_address)
            prb_pkg::OFS_RET_ADDR: ret_addr_ff <= merge(ret_addr_ff, avs_writedata, bmask);
            prb_pkg::OFS_ERR_ADDR: err_addr_ff <= merge(err_addr_ff, avs_writedata, bmask);
            prb_pkg::OFS_CONFIG: begin
               if (avs_byteenable[0]) begin
                  rev_ff        <= avs_writedata[prb_pkg::REV_LSB +: REV_W_L];
                  compressed_ff <= avs_writedata[prb_pkg::COMPRESSED_BIT];
                  r6_ff         <= avs_writedata[prb_pkg::R6_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // link reservation: a load-linked set wins over any clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         link_ff <= 1'b0;
      end else if (link_set_in) begin
         link_ff <= 1'b1;
      end else if (ret_go && is_ret) begin
         link_ff <= 1'b0;
      end else if (bus_wr && avs_address == prb_pkg::OFS_LINK && avs_byteenable[0]) begin
         link_ff <= avs_writedata[0];
      end
   end

   // ---------------------------------------------------------------
   // barrier sequencing and issue control
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_ff  <= PRB_IDLE;
         ready_ff  <= 1'b1;
         single_ff <= 1'b0;
      end else begin
         case (state_ff)
            PRB_IDLE: begin
               if (is_barrier) begin
                  // slot position is irrelevant: the stall is the same
                  state_ff  <= PRB_BARRIER;
                  ready_ff  <= 1'b0;
                  single_ff <= 1'b1;
               end
            end
            PRB_BARRIER: begin
               if (!exec_hazard_pending_in) begin
                  state_ff  <= PRB_IDLE;
                  ready_ff  <= 1'b1;
                  single_ff <= 1'b0;
               end
            end
            default: begin
               state_ff  <= PRB_IDLE;
               ready_ff  <= 1'b1;
               single_ff <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // hazard clear pulses
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         clr_exec_ff  <= 1'b0;
         clr_instr_ff <= 1'b0;
      end else begin
         clr_exec_ff  <= ret_go ||
                         (state_ff == PRB_BARRIER && !exec_hazard_pending_in);
         clr_instr_ff <= ret_go;
      end
   end

   // ---------------------------------------------------------------
   // general register write, redirect and exceptions
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gpr_ff     <= '0;
         redir_ff   <= '0;
         squash_ff  <= 1'b0;
         exc_cpu_ff <= 1'b0;
         exc_ri_ff  <= 1'b0;
      end else begin
         gpr_ff.en   <= int_go && (rt_idx != 5'h00);
         gpr_ff.idx  <= rt_idx;
         gpr_ff.data <= status_ff;
         redir_ff.valid <= ret_go;
         squash_ff      <= ret_go;
         if (ret_go) begin
            if (compressed_ff) begin
               redir_ff.pc       <= {ret_target[31:1], 1'b0};
               redir_ff.isa_mode <= ret_target[0];
            end else begin
               redir_ff.pc       <= ret_target;
               redir_ff.isa_mode <= 1'b0;
            end
         end
         exc_cpu_ff <= (is_int_en || any_ret) && !cp0_ok;
         exc_ri_ff  <= any_ret && cp0_ok && ret_slot_fault;
      end
   end

   // ---------------------------------------------------------------
   // running isa mode and last return target
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         isa_mode_ff <= 1'b0;
         last_pc_ff  <= '0;
      end else if (ret_go) begin
         isa_mode_ff <= compressed_ff && ret_target[0];
         last_pc_ff  <= compressed_ff ? {ret_target[31:1], 1'b0} : ret_target;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign instr_ready_out     = ready_ff;
   assign single_issue_out    = single_ff;
   assign gpr_wr_out          = gpr_ff;
   assign redirect_out        = redir_ff;
   assign squash_next_out     = squash_ff;
   assign clear_exec_haz_out  = clr_exec_ff;
   assign clear_instr_haz_out = clr_instr_ff;
   assign exc_cp_unusable_out = exc_cpu_ff;
   assign exc_reserved_out    = exc_ri_ff;
   assign link_flag_out       = link_ff;
   // new enable is visible one edge later; software still fences
   assign int_enable_out      = status_ff[prb_pkg::IE_BIT];
   assign avs_readdata        = rdata_ff;
   assign avs_waitrequest     = wait_ff;

endmodule : prb_core

//--- dv/prb_core_asserts.sv
/* prb_core_asserts: port-level checks of the barrier, enable and return unit.
   Assumes one clock domain and the registered one-cycle pulses of the core. */
`timescale 1ns/10ps
module prb_core_asserts (
   // clock and reset
   input wire logic                   clk_in,
   input wire logic                   sys_rst_in,
   // pipeline side
   input wire prb_pkg::prb_instr_t    instr_in,
   input wire logic                   exec_hazard_pending_in,
   input wire logic                   instr_ready_out,
   input wire logic                   single_issue_out,
   input wire prb_pkg::prb_gpr_wr_t   gpr_wr_out,
   input wire prb_pkg::prb_redirect_t redirect_out,
   input wire logic                   squash_next_out,
   input wire logic                   clear_exec_haz_out,
   input wire logic                   clear_instr_haz_out,
   input wire logic                   exc_cp_unusable_out,
   input wire logic                   exc_reserved_out,
   input wire logic                   link_flag_out,
   input wire logic                   int_enable_out,
   // bus side
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic                   avs_waitrequest
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire logic take = instr_in.valid && instr_ready_out;

   a_barrier_go: assert property (take && instr_in.word == prb_pkg::BARRIER_WORD |=>
      !instr_ready_out && single_issue_out) else $error("barrier did not stall issue");
   a_barrier_hold: assert property (!instr_ready_out && exec_hazard_pending_in |=>
      !instr_ready_out) else $error("issue resumed with hazard pending");
   a_barrier_done: assert property ($rose(instr_ready_out) |-> clear_exec_haz_out &&
      !clear_instr_haz_out) else $error("barrier release clears wrong hazards");
   a_single_wait: assert property (single_issue_out |-> !instr_ready_out)
      else $error("single issue outside barrier wait");
   a_ie_write: assert property (gpr_wr_out.en |-> int_enable_out)
      else $error("status written without enable set");
   a_ret_clears: assert property (redirect_out.valid |-> squash_next_out &&
      clear_exec_haz_out && clear_instr_haz_out) else $error("return lacks squash or clears");
   a_rsv_block: assert property (exc_reserved_out |-> !redirect_out.valid)
      else $error("return in slot still redirected");
   a_cpu_block: assert property (exc_cp_unusable_out |-> !redirect_out.valid &&
      !gpr_wr_out.en) else $error("unusable op still executed");
   a_link_keep: assert property (take && instr_in.word == prb_pkg::RETURN_KEEP_WORD &&
      link_flag_out |=> link_flag_out) else $error("keep-link return lost link flag");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
endmodule : prb_core_asserts

bind prb_core prb_core_asserts prb_core_asserts_i (.clk_in, .sys_rst_in, .instr_in,
   .exec_hazard_pending_in, .instr_ready_out, .single_issue_out, .gpr_wr_out, .redirect_out,
   .squash_next_out, .clear_exec_haz_out, .clear_instr_haz_out, .exc_cp_unusable_out,
   .exc_reserved_out, .link_flag_out, .int_enable_out, .avs_read, .avs_write, .avs_waitrequest);

//--- dv/prb_core_tb.sv
/* prb_core_tb: self-checking bench for prb_core against a bench-side model.
   Assumes the one-wait-cycle bus slave and one-cycle result pulses of the core. */
`timescale 1ns/10ps
module prb_core_tb;
   logic                   clk_in = 1'b0;
   logic                   sys_rst_in = 1'b1;
   prb_pkg::prb_instr_t    instr_in = '0;
   logic                   kernel_mode_in = 1'b1;
   logic                   exec_hazard_pending_in = 1'b0;
   logic                   link_set_in = 1'b0;
   logic [4:0]             avs_address = 5'h00;
   logic                   avs_read = 1'b0;
   logic                   avs_write = 1'b0;
   logic [31:0]            avs_writedata = 32'h0;
   logic [3:0]             avs_byteenable = 4'hf;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest, instr_ready_out, single_issue_out, squash_next_out;
   logic                   clear_exec_haz_out, clear_instr_haz_out, exc_cp_unusable_out;
   logic                   exc_reserved_out, link_flag_out, int_enable_out;
   prb_pkg::prb_gpr_wr_t   gpr_wr_out, gw;
   prb_pkg::prb_redirect_t redirect_out, rd;
   logic [4:0]             fl;
   logic [31:0]            st_m, ss_m, cfg_m, adr, q, w;
   int                     error_cnt = 0;
   int                     cmp_count = 0;

   prb_core prb_core_i (.clk_in, .sys_rst_in, .instr_in, .kernel_mode_in, .exec_hazard_pending_in,
      .link_set_in, .instr_ready_out, .single_issue_out, .gpr_wr_out, .redirect_out,
      .squash_next_out, .clear_exec_haz_out, .clear_instr_haz_out, .exc_cp_unusable_out,
      .exc_reserved_out, .link_flag_out, .int_enable_out, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

   always #10 clk_in = ~clk_in;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // one instruction, then three cycles of pulses gathered
   task automatic op(input logic [31:0] wd, input logic slot);
      @(posedge clk_in);
      instr_in <= {1'b1, wd, slot};
      @(posedge clk_in);
      instr_in <= '0;
      fl = '0;
      gw = '0;
      rd = '0;
      repeat (3) begin
         #1;
         if (gpr_wr_out.en === 1'b1) gw = gpr_wr_out;
         if (redirect_out.valid === 1'b1) rd = redirect_out;
         fl |= {squash_next_out === 1'b1, clear_exec_haz_out === 1'b1,
                clear_instr_haz_out === 1'b1, exc_cp_unusable_out === 1'b1,
                exc_reserved_out === 1'b1};
         @(posedge clk_in);
      end
   endtask : op

   task automatic link_pulse();
      @(posedge clk_in);
      link_set_in <= 1'b1;
      @(posedge clk_in);
      link_set_in <= 1'b0;
   endtask : link_pulse

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h188c));
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      st_m = prb_pkg::STATUS_RST;
      cfg_m = (32'h1 << prb_pkg::KEEP_LINK_BIT) | 32'(prb_pkg::REV_RST);
      bus(1'b0, prb_pkg::OFS_STATUS, 32'h0);
      chk("status reset", st_m, q);
      bus(1'b0, prb_pkg::OFS_CONFIG, 32'h0);
      chk("config reset", cfg_m, q);
      bus(1'b0, 5'h1c, 32'h0);
      chk("unmapped read", 32'h0, q);
      $display("test reset done");
      w = 32'($urandom_range(31, 1));
      op(prb_pkg::INT_ENABLE_MATCH | (w << prb_pkg::RT_LSB), 1'b0);
      chk("gpr write", {1'b1, w[4:0]}, {gw.en, gw.idx});
      chk("gpr data", st_m, gw.data);
      chk("enable bit", 32'h1, int_enable_out);
      st_m = st_m & ~32'h1;
      bus(1'b1, prb_pkg::OFS_STATUS, st_m);
      kernel_mode_in <= 1'b0;
      op(prb_pkg::INT_ENABLE_MATCH, 1'b0);
      chk("enable refused", 32'h4, {fl[1], gw.en, int_enable_out});
      op(prb_pkg::RETURN_WORD, 1'b0);
      chk("return refused", 32'h2, {fl[1], rd.valid});
      kernel_mode_in <= 1'b1;
      $display("test enable done");
      cfg_m = cfg_m | (32'h1 << prb_pkg::COMPRESSED_BIT);
      bus(1'b1, prb_pkg::OFS_CONFIG, cfg_m);
      adr = $urandom;
      bus(1'b1, prb_pkg::OFS_ERR_ADDR, adr);
      link_pulse();
      op(prb_pkg::RETURN_WORD, 1'b0);
      chk("error pc", {adr[31:1], 1'b0}, rd.pc);
      chk("isa mode", 32'(adr[0]), rd.isa_mode);
      chk("return pulses", 32'h1c, fl);
      chk("link cleared", 32'h0, link_flag_out);
      st_m = st_m & ~(32'h1 << prb_pkg::ERL_BIT);
      bus(1'b0, prb_pkg::OFS_STATUS, 32'h0);
      chk("error level", st_m, q);
      cfg_m = cfg_m & ~(32'h1 << prb_pkg::COMPRESSED_BIT);
      bus(1'b1, prb_pkg::OFS_CONFIG, cfg_m);
      $display("test error return done");
      // boot vector 0 restores the shadow set, 1 keeps it
      for (int b = 0; b < 2; b++) begin
         st_m = (32'(b) << prb_pkg::BEV_BIT) | (32'h1 << prb_pkg::EXL_BIT);
         bus(1'b1, prb_pkg::OFS_STATUS, st_m);
         ss_m = (32'h3 << prb_pkg::HSS_LSB) | (32'h5 << prb_pkg::PSS_LSB) | 32'h1;
         bus(1'b1, prb_pkg::OFS_SHADOW, ss_m);
         adr = $urandom;
         bus(1'b1, prb_pkg::OFS_RET_ADDR, adr);
         link_pulse();
         op(b == 0 ? prb_pkg::RETURN_KEEP_WORD : prb_pkg::RETURN_WORD, 1'b0);
         chk("return pc", adr, rd.pc);
         chk("link after", 32'(b == 0), link_flag_out);
         bus(1'b0, prb_pkg::OFS_SHADOW, 32'h0);
         chk("shadow set", b == 0 ? (ss_m & ~32'hf) | 32'h5 : ss_m, q);
         bus(1'b0, prb_pkg::OFS_STATUS, 32'h0);
         chk("exc level", st_m & ~(32'h1 << prb_pkg::EXL_BIT), q);
      end
      $display("test exception return done");
      bus(1'b1, prb_pkg::OFS_CONFIG, cfg_m | (32'h1 << prb_pkg::R6_BIT));
      for (int k = 0; k < 2; k++) begin
         op(k == 0 ? prb_pkg::RETURN_WORD : prb_pkg::RETURN_KEEP_WORD, 1'b1);
         chk("slot return", 32'h2, {fl, rd.valid});
      end
      $display("test slot return done");
      exec_hazard_pending_in <= 1'b1;
      op(prb_pkg::BARRIER_WORD, 1'b1);
      exec_hazard_pending_in <= 1'b0;
      #1;
      chk("barrier stall", 32'h1, {instr_ready_out, single_issue_out});
      chk("no early clear", 32'h0, fl);
      for (int n = 0; n < 10 && instr_ready_out !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
      chk("barrier clear", 32'h2, {clear_exec_haz_out, clear_instr_haz_out});
      $display("test barrier done");
      wrap_up();
   end

   // far above the roughly 130 cycles needed
   initial begin
      #200_000;
      error_cnt++;
      $display("ERROR watchdog expected finish seen timeout");
      wrap_up();
   end
endmodule : prb_core_tb
